// *** rtl/nvmem_pkg.sv ***
// Contract
// - Store holds sixty-four bytes of eight bits at addresses 0x00 to 0x3f.
// - Store is reached only through address, data and control registers, one byte each.
// - Address and data registers are read and written directly in bank 0.
// - Address register holds a readable, writable six-bit address in bits 5 to 0.
// - Address register bits 7 and 6 always read as zero.
// - Three registers; control has store/fetch permit and store/fetch start bits 3 to 0.
// - Fetch start acts only with fetch permit already set; cleared when byte is loaded.
// - Store start acts only with store permit set beforehand; cleared when write ends.
// - Data register keeps the fetched byte until the next read or write operation.
package nvmem_pkg;

    // ****************************************************************
    // Register map and fields.
    // ****************************************************************
    localparam logic [7:0] ADDR_OFFSET    = 8'h2c;
    localparam logic [7:0] DATA_OFFSET    = 8'h2d;
    localparam logic [7:0] CONTROL_OFFSET = 8'h40;
    localparam logic       CONTROL_BANK   = 1'b1;
    localparam int         STORE_PERMIT   = 3;
    localparam int         STORE_START    = 2;
    localparam int         FETCH_PERMIT   = 1;
    localparam int         FETCH_START    = 0;
    localparam logic [7:0] RESET_VALUE    = 8'h00;
    localparam int         DEPTH          = 64;
    localparam int         READ_CYCLES    = 4;
    localparam int         WRITE_CYCLES   = 1000;

    // ****************************************************************
    // Register access request from the core.
    // ****************************************************************
    typedef struct packed {
        logic       we;
        logic       re;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvmem_req_t;

    typedef enum logic [2:0] {
        NVMEM_IDLE  = 3'b001,
        NVMEM_READ  = 3'b010,
        NVMEM_WRITE = 3'b100
    } nvmem_state_t;

endpackage

// *** rtl/nvmem_access.sv ***
`timescale 1ns/1ns
module nvmem_access #(
    parameter int READ_CYCLES  = nvmem_pkg::READ_CYCLES,
    parameter int WRITE_CYCLES = nvmem_pkg::WRITE_CYCLES
) (
    // Clock and reset.
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Register access from the core.
    input  wire nvmem_pkg::nvmem_req_t  req,
    output logic [7:0]                  sfr_rdata
);

    logic [7:0]              mem [nvmem_pkg::DEPTH];
    logic [5:0]              nv_address;
    logic [7:0]              nv_data;
    logic                    store_permit;
    logic                    store_start;
    logic                    fetch_permit;
    logic                    fetch_start;
    nvmem_pkg::nvmem_state_t state;
    logic [19:0]             cnt;
    logic [5:0]              op_addr;
    logic [7:0]              op_data;
    logic [7:0]              read_word;
    logic                    hit_addr;
    logic                    hit_data;
    logic                    hit_ctrl;
    logic                    go_read;
    logic                    go_write;
    logic                    done;
    logic [7:0]              next_rdata;

    // ****************************************************************
    // Decode.
    // ****************************************************************

    // Address and data sit in the special area seen from any bank.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Decode the three registers; control only answers in bank 1.
    assign hit_addr  = hit(req.addr, nvmem_pkg::ADDR_OFFSET);
    assign hit_data  = hit(req.addr, nvmem_pkg::DATA_OFFSET);
    assign hit_ctrl  = hit(req.addr, nvmem_pkg::CONTROL_OFFSET) && (req.bank == nvmem_pkg::CONTROL_BANK);
    // A start is taken only when its permit was already set before this write.
    assign go_read   = (state == nvmem_pkg::NVMEM_IDLE) && req.we && hit_ctrl &&
                       req.wdata[nvmem_pkg::FETCH_START] && fetch_permit;
    assign go_write  = (state == nvmem_pkg::NVMEM_IDLE) && req.we && hit_ctrl && !go_read &&
                       req.wdata[nvmem_pkg::STORE_START] && store_permit;
    assign done      = (state != nvmem_pkg::NVMEM_IDLE) && (cnt == 20'h00000);
    assign read_word = mem[op_addr];

    // ****************************************************************
    // Registers.
    // ****************************************************************

    // Address register, six bits wide.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_address <= nvmem_pkg::RESET_VALUE[5:0];
        end else if (req.we && hit_addr) begin
            nv_address <= req.wdata[5:0];
        end
    end

    // Data register: software writes, or the fetched byte at read end.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_data <= nvmem_pkg::RESET_VALUE;
        end else if (done && state == nvmem_pkg::NVMEM_READ) begin
            nv_data <= read_word;
        end else if (req.we && hit_data) begin
            nv_data <= req.wdata;
        end
    end

    // Permit bits are plain read-write bits.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            store_permit <= 1'b0;
            fetch_permit <= 1'b0;
        end else if (req.we && hit_ctrl) begin
            store_permit <= req.wdata[nvmem_pkg::STORE_PERMIT];
            fetch_permit <= req.wdata[nvmem_pkg::FETCH_PERMIT];
        end
    end

    // Start bits rise on an accepted start and fall when the cycle ends.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_start <= 1'b0;
            store_start <= 1'b0;
        end else if (done) begin
            fetch_start <= 1'b0;
            store_start <= 1'b0;
        end else begin
            fetch_start <= fetch_start | go_read;
            store_start <= store_start | go_write;
        end
    end

    // ****************************************************************
    // Cycle sequencer.
    // ****************************************************************

    // Latch address and data at the start, so later writes do not disturb the cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state   <= nvmem_pkg::NVMEM_IDLE;
            cnt     <= 20'h00000;
            op_addr <= 6'h00;
            op_data <= 8'h00;
        end else begin
            case (state)
                nvmem_pkg::NVMEM_IDLE: begin
                    op_addr <= nv_address;
                    op_data <= nv_data;
                    if (go_read) begin
                        state <= nvmem_pkg::NVMEM_READ;
                        cnt   <= 20'(READ_CYCLES - 1);
                    end else if (go_write) begin
                        state <= nvmem_pkg::NVMEM_WRITE;
                        cnt   <= 20'(WRITE_CYCLES - 1);
                    end
                end
                nvmem_pkg::NVMEM_READ, nvmem_pkg::NVMEM_WRITE: begin
                    if (done) begin
                        state <= nvmem_pkg::NVMEM_IDLE;
                    end else begin
                        cnt <= cnt - 20'h00001;
                    end
                end
                default: begin
                    state <= nvmem_pkg::NVMEM_IDLE;
                end
            endcase
        end
    end

    // The byte array is written once, at the end of a write cycle; it holds no reset.
    always_ff @(posedge ref_clk) begin
        if (done && state == nvmem_pkg::NVMEM_WRITE) begin
            mem[op_addr] <= op_data;
        end
    end

    // ****************************************************************
    // Read data.
    // ****************************************************************

    // Unused and unmapped bits read as zero.
    always_comb begin
        next_rdata = 8'h00;
        if (hit_addr) begin
            next_rdata = {2'b00, nv_address};
        end else if (hit_data) begin
            next_rdata = nv_data;
        end else if (hit_ctrl) begin
            next_rdata = {4'h0, store_permit, store_start, fetch_permit, fetch_start};
        end
    end

    // Read answer is registered, one cycle after the request.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (req.re) begin
            sfr_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_addr_write;
        req.we && hit_addr |=> nv_address == $past(req.wdata[5:0]);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("Address register did not take the write.");

    property p_addr_high_zero;
        req.re && hit_addr |=> sfr_rdata[7:6] == 2'b00;
    endproperty
    a_addr_high_zero: assert property (p_addr_high_zero) else $error("Address high bits not zero.");

    property p_data_write;
        req.we && hit_data && state == nvmem_pkg::NVMEM_IDLE |=> nv_data == $past(req.wdata);
    endproperty
    a_data_write: assert property (p_data_write) else $error("Data register did not take the write.");

    property p_unmapped;
        req.re && !hit_addr && !hit_data && !hit_ctrl |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");

    property p_ctrl_high_zero;
        req.re && hit_ctrl |=> sfr_rdata[7:4] == 4'h0;
    endproperty
    a_ctrl_high_zero: assert property (p_ctrl_high_zero) else $error("Control high bits not zero.");

    property p_fetch_refused;
        state == nvmem_pkg::NVMEM_IDLE && !fetch_permit && !fetch_start |=> !fetch_start;
    endproperty
    a_fetch_refused: assert property (p_fetch_refused) else $error("Read started without permit.");

    property p_store_refused;
        state == nvmem_pkg::NVMEM_IDLE && !store_permit && !store_start |=> !store_start;
    endproperty
    a_store_refused: assert property (p_store_refused) else $error("Write started without permit.");

    property p_read_end;
        done && state == nvmem_pkg::NVMEM_READ |=> !fetch_start && nv_data == $past(read_word);
    endproperty
    a_read_end: assert property (p_read_end) else $error("Read end wrong.");

    property p_start_held;
        state != nvmem_pkg::NVMEM_IDLE |-> (fetch_start || store_start);
    endproperty
    a_start_held: assert property (p_start_held) else $error("Start bit low during cycle.");

    property p_data_kept;
        state == nvmem_pkg::NVMEM_IDLE && !(req.we && hit_data) |=> $stable(nv_data);
    endproperty
    a_data_kept: assert property (p_data_kept) else $error("Data register changed while idle.");

    property p_write_end;
        done && state == nvmem_pkg::NVMEM_WRITE |=> mem[$past(op_addr)] == $past(op_data) && !store_start;
    endproperty
    a_write_end: assert property (p_write_end) else $error("Write end wrong.");

    c_read:    cover property (done && state == nvmem_pkg::NVMEM_READ);
    c_write:   cover property (done && state == nvmem_pkg::NVMEM_WRITE);
    c_refused: cover property (req.we && hit_ctrl && req.wdata[nvmem_pkg::FETCH_START] && !fetch_permit);

endmodule // nvmem_access

// *** bench/nvmem_access_test.sv ***
`timescale 1ns/1ns
module nvmem_access_test;

    // ****************************************************************
    // Clock, reset and the block under test.
    // ****************************************************************
    logic                  ref_clk;
    logic                  rst;
    nvmem_pkg::nvmem_req_t req;
    logic [7:0]            sfr_rdata;
    logic [7:0]            mem_model [64];
    int                    err_count;
    int                    check_count;

    nvmem_access #(.READ_CYCLES(4), .WRITE_CYCLES(8)) dut_u (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .req       (req),
        .sfr_rdata (sfr_rdata)
    );

    // The clock toggles every half period of 10 ns.
    always #10 ref_clk = ~ref_clk;

    // ****************************************************************
    // Bus tasks and comparisons.
    // ****************************************************************
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One write strobe, held for exactly one taking edge.
    task automatic wr(input logic bank, input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        req <= '{we: 1'b1, re: 1'b0, bank: bank, addr: addr, wdata: data};
        @(posedge ref_clk);
        req.we <= 1'b0;
    endtask

    // One read strobe; the answer is settled the cycle after the taking edge.
    task automatic rd(input logic bank, input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        req <= '{we: 1'b0, re: 1'b1, bank: bank, addr: addr, wdata: 8'h00};
        @(posedge ref_clk);
        req.re <= 1'b0;
        @(negedge ref_clk);
        data = sfr_rdata;
    endtask

    // Expected address read-back: the upper two bits never show.
    function automatic logic [7:0] addr_exp(input logic [7:0] v);
        return {2'b00, v[5:0]};
    endfunction

    // Polls a start bit until the cycle ends, under a bounded count.
    task automatic poll(input int bit_pos);
        logic [7:0] got;
        int         n;
        n = 0;
        do begin
            rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
            n++;
        end while (got[bit_pos] === 1'b1 && n < 100);
        check("start bit cleared", 8'h00, {7'h00, got[bit_pos]});
    endtask

    task automatic store_byte(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] got;
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h08);
        wr(1'b0, nvmem_pkg::ADDR_OFFSET, {2'b00, a});
        wr(1'b0, nvmem_pkg::DATA_OFFSET, d);
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h0c);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("store start busy", 8'h0c, got);
        poll(nvmem_pkg::STORE_START);
        mem_model[a] = d;
    endtask

    task automatic fetch_byte(input logic [5:0] a, output logic [7:0] d);
        logic [7:0] got;
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h02);
        wr(1'b0, nvmem_pkg::ADDR_OFFSET, {2'b00, a});
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h03);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("fetch start busy", 8'h03, got);
        poll(nvmem_pkg::FETCH_START);
        rd(1'b0, nvmem_pkg::DATA_OFFSET, d);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        logic [7:0] v;
        logic [7:0] got;
        logic [5:0] a;
        logic [5:0] used [$];
        ref_clk = 1'b0;
        rst = 1'b1;
        req = '0;
        err_count = 0;
        check_count = 0;
        void'($urandom(96));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("control after reset", 8'h00, got);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            wr(1'b0, nvmem_pkg::ADDR_OFFSET, v);
            rd(1'b0, nvmem_pkg::ADDR_OFFSET, got);
            check("address reg", addr_exp(v), got);
            v = 8'($urandom);
            wr(1'b0, nvmem_pkg::DATA_OFFSET, v);
            rd(1'b0, nvmem_pkg::DATA_OFFSET, got);
            check("data reg", v, got);
        end
        $display("test direct registers done");
        wr(1'b0, nvmem_pkg::CONTROL_OFFSET, 8'h0a);
        rd(1'b0, nvmem_pkg::CONTROL_OFFSET, got);
        check("control via bank 0", 8'h00, got);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("control untouched", 8'h00, got);
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'hf0);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("control upper bits", 8'h00, got);
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h01);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("fetch start no permit", 8'h00, got);
        wr(1'b1, nvmem_pkg::CONTROL_OFFSET, 8'h04);
        rd(1'b1, nvmem_pkg::CONTROL_OFFSET, got);
        check("store start no permit", 8'h00, got);
        $display("test control refusals done");
        for (int i = 0; i < 12; i++) begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
            store_byte(a, 8'($urandom));
            used.push_back(a);
        end
        foreach (used[i]) begin
            fetch_byte(used[i], got);
            check("fetched byte", mem_model[used[i]], got);
        end
        $display("test store and fetch done");
        wr(1'b0, nvmem_pkg::ADDR_OFFSET, 8'h15);
        repeat (10) @(posedge ref_clk);
        rd(1'b0, nvmem_pkg::DATA_OFFSET, v);
        check("data kept", mem_model[used[used.size() - 1]], v);
        $display("test data hold done");
        stop_test();
    end

    // Cuts a hang short at ten thousand cycles, several times the expected run.
    initial begin
        #200000;
        err_count++;
        stop_test();
    end

endmodule // nvmem_access_test
